/* logic/fio_port.sv */
// Fast general-purpose I/O port with core-side and DMA-side register access
`timescale 1ns/1ps
`default_nettype none
module fio_port
  import fio_pkg::*;
#(
  parameter int PORT_INDEX = 0,
  parameter logic [31:0] PIN_IMPL_MASK = 32'hffff_ffff
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Single-cycle core port
  input wire logic core_sel_in,
  input wire logic core_write_in,
  input wire logic [31:0] core_addr_in,
  input wire logic [31:0] core_wdata_in,
  output logic [31:0] core_rdata_out,
  // System bus port used by the DMA
  input wire logic dma_sel_in,
  input wire logic dma_write_in,
  input wire logic [31:0] dma_addr_in,
  input wire logic [31:0] dma_wdata_in,
  output logic [31:0] dma_rdata_out,
  output logic dma_ready_out,
  output logic dma_rvalid_out,
  // Mode and port control status
  input wire logic compute_mode_in,
  input wire logic port_ctrl_en_in,
  input wire logic [31:0] pin_digital_in,
  input wire logic [31:0] pin_gpio_in,
  // Pins
  input wire logic [31:0] pin_level_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n_out
);
  // ==========================================================
  // Address window and storage
  // Port window in absolute addresses
  localparam logic [31:0] PORT_BASE = FIO_CORE_BASE + FIO_PORT_STRIDE * PORT_INDEX;
  localparam logic [31:0] WIN_MASK = ~(FIO_PORT_STRIDE - 32'h0000_0001);

  logic [31:0] output_level_reg;
  logic [31:0] output_level_next;
  logic [31:0] direction_reg;
  logic [31:0] direction_next;
  logic [31:0] input_level_reg;
  logic [31:0] input_level_next;
  logic [31:0] core_rdata_reg;
  logic [31:0] dma_rdata_reg;
  logic dma_rvalid_reg;
  logic [31:0] pin_sync;

  // Pin levels pass two flip-flops before use
  fio_sync2 #(.WIDTH(FIO_DATA_W)) u_sync
  (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(pin_level_in),
    .sync_out(pin_sync)
  );

  // ==========================================================
  // Access selection
  // Address decode of both masters into this port's window
  wire core_hit = core_sel_in && ((core_addr_in & WIN_MASK) == PORT_BASE);
  wire dma_hit = dma_sel_in && ((dma_addr_in & WIN_MASK) == PORT_BASE);
  wire core_grant;
  wire dma_grant;
  wire dma_stall;

  // Core port wins collisions; compute mode shuts the DMA out
  fio_arbiter u_arb
  (
    .core_sel_in(core_hit),
    .dma_sel_in(dma_hit),
    .compute_mode_in(compute_mode_in),
    .core_grant_out(core_grant),
    .dma_grant_out(dma_grant),
    .dma_stall_out(dma_stall)
  );

  // Selected access that reaches the registers this cycle
  wire acc_write = core_grant ? core_write_in : dma_write_in;
  wire [5:0] acc_ofs = core_grant ? core_addr_in[5:0] : dma_addr_in[5:0];
  wire [31:0] acc_wdata = core_grant ? core_wdata_in : dma_wdata_in;
  wire acc_valid = core_grant || dma_grant;
  wire acc_wr = acc_valid && acc_write;
  wire acc_rd = acc_valid && !acc_write;

  // ==========================================================
  // Register updates
  // Write kind decode
  wire wr_direct = acc_wr && (acc_ofs == FIO_OFS_OUTPUT_LEVEL);
  wire wr_set = acc_wr && (acc_ofs == FIO_OFS_SET);
  wire wr_clear = acc_wr && (acc_ofs == FIO_OFS_CLEAR);
  wire wr_toggle = acc_wr && (acc_ofs == FIO_OFS_TOGGLE);
  wire wr_dir = acc_wr && (acc_ofs == FIO_OFS_DIRECTION);
  fio_wr_e wr_kind;

  always_comb
  begin
    wr_kind = FIO_WR_NONE;
    if (wr_direct)
      wr_kind = FIO_WR_DIRECT;
    else if (wr_set)
      wr_kind = FIO_WR_SET;
    else if (wr_clear)
      wr_kind = FIO_WR_CLEAR;
    else if (wr_toggle)
      wr_kind = FIO_WR_TOGGLE;
  end

  // Next output level; unwritten bits hold, any number of bits may change
  always_comb
  begin
    output_level_next = output_level_reg;
    unique case (wr_kind)
      FIO_WR_NONE: output_level_next = output_level_reg;
      FIO_WR_DIRECT: output_level_next = acc_wdata;
      FIO_WR_SET: output_level_next = output_level_reg | acc_wdata;
      FIO_WR_CLEAR: output_level_next = output_level_reg & ~acc_wdata;
      FIO_WR_TOGGLE: output_level_next = output_level_reg ^ acc_wdata;
      default: output_level_next = output_level_reg;
    endcase
  end

  // Direction and output writes ignore the port control enable
  assign direction_next = wr_dir ? acc_wdata : direction_reg;

  // Input level refresh: frozen when port control is off or in compute mode
  wire input_refresh = port_ctrl_en_in && !compute_mode_in;
  assign input_level_next = input_refresh ? (pin_sync & pin_digital_in & PIN_IMPL_MASK)
                                          : input_level_reg;

  // ==========================================================
  // Read path
  // Read data mux; strobe registers and unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = FIO_ZERO_WORD;
    if (acc_ofs == FIO_OFS_OUTPUT_LEVEL)
      rd_mux = output_level_reg & PIN_IMPL_MASK;
    else if (acc_ofs == FIO_OFS_INPUT_LEVEL)
      rd_mux = input_level_reg;
    else if (acc_ofs == FIO_OFS_DIRECTION)
      rd_mux = direction_reg & PIN_IMPL_MASK;
  end

  // State registers
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      output_level_reg <= FIO_RST_OUTPUT_LEVEL;
      direction_reg <= FIO_RST_DIRECTION;
      input_level_reg <= FIO_RST_INPUT_LEVEL;
    end
    else
    begin
      output_level_reg <= output_level_next;
      direction_reg <= direction_next;
      input_level_reg <= input_level_next;
    end
  end

  // Read data registers for both masters
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      core_rdata_reg <= FIO_ZERO_WORD;
      dma_rdata_reg <= FIO_ZERO_WORD;
      dma_rvalid_reg <= 1'b0;
    end
    else
    begin
      core_rdata_reg <= (core_grant && acc_rd) ? rd_mux : FIO_ZERO_WORD;
      dma_rdata_reg <= (dma_grant && acc_rd) ? rd_mux : dma_rdata_reg;
      dma_rvalid_reg <= dma_grant && acc_rd;
    end
  end

  assign core_rdata_out = core_rdata_reg;
  assign dma_rdata_out = dma_rdata_reg;
  assign dma_rvalid_out = dma_rvalid_reg;
  assign dma_ready_out = !dma_stall;

  // ==========================================================
  // Pin drive
  // Pin drive: GPIO pins with direction one drive output level, low-active enable
  wire [31:0] drive_en = direction_reg & pin_gpio_in & PIN_IMPL_MASK;
  assign pin_out = output_level_reg & drive_en;
  assign pin_oe_n_out = ~drive_en;

  // ==========================================================
  // Assertions
  logic past_valid_reg;
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      past_valid_reg <= 1'b0;
    else
      past_valid_reg <= 1'b1;
  end

  // Output level and direction updates
  a_reset_values: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !past_valid_reg |-> output_level_reg == FIO_RST_OUTPUT_LEVEL && direction_reg == FIO_RST_DIRECTION
    && input_level_reg == FIO_RST_INPUT_LEVEL)
    else $error("register not at reset value");
  a_direct_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_direct |=> output_level_reg == $past(acc_wdata))
    else $error("direct write wrong");
  a_set_bits: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_set |=> output_level_reg == ($past(output_level_reg) | $past(acc_wdata)))
    else $error("set write wrong");
  a_clear_bits: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_clear |=> output_level_reg == ($past(output_level_reg) & ~$past(acc_wdata)))
    else $error("clear write wrong");
  a_toggle_bits: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_toggle |=> output_level_reg == ($past(output_level_reg) ^ $past(acc_wdata)))
    else $error("toggle write wrong");
  a_strobe_keeps: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wr_set || wr_clear || wr_toggle)
    |=> ((output_level_reg ^ $past(output_level_reg)) & ~$past(acc_wdata)) == FIO_ZERO_WORD)
    else $error("unwritten output bit changed");
  a_hold_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !acc_wr |=> $stable(output_level_reg) && $stable(direction_reg))
    else $error("registers changed without write");
  a_writes_unlocked: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !port_ctrl_en_in && wr_dir |=> direction_reg == $past(acc_wdata))
    else $error("direction write lost while port control off");

  // Address windows and core port
  a_core_hit_base: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_sel_in && core_addr_in[31:6] == PORT_BASE[31:6] |-> core_grant)
    else $error("core access to window not granted");
  a_window_only: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_sel_in && core_addr_in[31:6] != PORT_BASE[31:6] && !dma_grant |=> $stable(direction_reg))
    else $error("access outside window changed direction");
  a_other_port: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_sel_in && core_write_in && core_addr_in[31:6] != PORT_BASE[31:6] && !dma_grant
    |=> $stable(output_level_reg))
    else $error("write to another port changed output level");
  a_core_write_now: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_hit && core_write_in && core_addr_in[5:0] == FIO_OFS_DIRECTION
    |=> direction_reg == $past(core_wdata_in))
    else $error("core write not in one cycle");
  a_core_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (core_hit && !core_write_in && core_addr_in[5:0] == FIO_OFS_DIRECTION)
    |=> core_rdata_out == ($past(direction_reg) & PIN_IMPL_MASK))
    else $error("core read not one cycle");
  a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(core_grant && acc_rd) |=> core_rdata_out == FIO_ZERO_WORD)
    else $error("core read data without read");
  a_output_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_hit && !core_write_in && core_addr_in[5:0] == FIO_OFS_OUTPUT_LEVEL
    |=> core_rdata_out == ($past(output_level_reg) & PIN_IMPL_MASK))
    else $error("output level read wrong");
  a_input_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_hit && !core_write_in && core_addr_in[5:0] == FIO_OFS_INPUT_LEVEL
    |=> core_rdata_out == $past(input_level_reg))
    else $error("input level read wrong");
  a_strobe_reads_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    core_grant && acc_rd && (acc_ofs == FIO_OFS_SET || acc_ofs == FIO_OFS_CLEAR || acc_ofs == FIO_OFS_TOGGLE)
    |=> core_rdata_out == FIO_ZERO_WORD)
    else $error("strobe read not zero");

  // Input sampling
  a_input_sampled: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    port_ctrl_en_in && !compute_mode_in
    |=> input_level_reg == ($past(pin_sync) & $past(pin_digital_in) & PIN_IMPL_MASK))
    else $error("input level not sampled");
  a_input_frozen: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!port_ctrl_en_in || compute_mode_in) |=> $stable(input_level_reg))
    else $error("input level updated while frozen");
  a_compute_frozen: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    compute_mode_in |=> $stable(input_level_reg))
    else $error("input level updated in compute mode");
  a_input_masked: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    past_valid_reg |-> (input_level_reg & ~PIN_IMPL_MASK) == FIO_ZERO_WORD)
    else $error("unimplemented input bit set");

  // Pin drive
  a_pin_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pin_out & ~(direction_reg & pin_gpio_in)) == FIO_ZERO_WORD
    && (~pin_oe_n_out & ~direction_reg) == FIO_ZERO_WORD)
    else $error("input pin driven");
  a_drive_level: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ((pin_out ^ output_level_reg) & ~pin_oe_n_out) == FIO_ZERO_WORD
    && (~pin_oe_n_out ^ (direction_reg & pin_gpio_in & PIN_IMPL_MASK)) == FIO_ZERO_WORD)
    else $error("driven pin level wrong");
  a_unimpl_pins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (~pin_oe_n_out & ~PIN_IMPL_MASK) == FIO_ZERO_WORD)
    else $error("unimplemented pin driven");

  // Arbitration between core port and DMA
  a_dma_stall: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (dma_hit && core_hit) |-> !dma_ready_out && !dma_grant)
    else $error("dma not stalled on collision");
  a_dma_alone: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    dma_hit && !core_hit && !compute_mode_in |-> dma_ready_out)
    else $error("dma stalled without reason");
  a_dma_read_data: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    dma_grant && !dma_write_in && dma_addr_in[5:0] == FIO_OFS_DIRECTION
    |=> dma_rvalid_out && dma_rdata_out == ($past(direction_reg) & PIN_IMPL_MASK))
    else $error("dma read data wrong");
  a_compute_dma: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (dma_hit && compute_mode_in) |-> !dma_grant ##1 !dma_rvalid_out)
    else $error("dma access in compute mode");
  a_rvalid_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(dma_grant && acc_rd) |=> !dma_rvalid_out)
    else $error("dma read valid without read");

  // Coverage of the main scenarios
  c_set_write: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) wr_set && core_grant);
  c_collision: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) dma_hit && core_hit);
  c_dma_read: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) dma_rvalid_out);
  c_frozen: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) compute_mode_in && core_grant);
  c_dma_write: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) dma_grant && acc_wr);
endmodule
`default_nettype wire

/* logic/fio_pkg.sv */
// Package with register map, reset values and sizes of the fast I/O port
package fio_pkg;
  localparam int FIO_DATA_W = 32;
  localparam int FIO_ADDR_W = 32;
  // Base address of the first port on the core port, and stride between ports
  localparam logic [31:0] FIO_CORE_BASE = 32'hf800_0000;
  localparam logic [31:0] FIO_PORT_STRIDE = 32'h0000_0040;
  // Register offsets within one port window
  localparam logic [5:0] FIO_OFS_OUTPUT_LEVEL = 6'h00;
  localparam logic [5:0] FIO_OFS_SET = 6'h04;
  localparam logic [5:0] FIO_OFS_CLEAR = 6'h08;
  localparam logic [5:0] FIO_OFS_TOGGLE = 6'h0c;
  localparam logic [5:0] FIO_OFS_INPUT_LEVEL = 6'h10;
  localparam logic [5:0] FIO_OFS_DIRECTION = 6'h14;
  // Reset values
  localparam logic [31:0] FIO_RST_OUTPUT_LEVEL = 32'h0000_0000;
  localparam logic [31:0] FIO_RST_DIRECTION = 32'h0000_0000;
  localparam logic [31:0] FIO_RST_INPUT_LEVEL = 32'h0000_0000;
  localparam logic [31:0] FIO_ZERO_WORD = 32'h0000_0000;
  // Timing: clock period and the single-cycle core access
  localparam int FIO_CLK_PERIOD_PS = 4000;
  localparam int FIO_CORE_ACCESS_PS = 4000;
  localparam int FIO_CORE_ACCESS_CYC = (FIO_CORE_ACCESS_PS + FIO_CLK_PERIOD_PS - 1) / FIO_CLK_PERIOD_PS;
  // Kinds of write that reach the output level register
  typedef enum logic [2:0]
  {
    FIO_WR_NONE = 3'b000,
    FIO_WR_DIRECT = 3'b001,
    FIO_WR_SET = 3'b010,
    FIO_WR_CLEAR = 3'b011,
    FIO_WR_TOGGLE = 3'b100
  } fio_wr_e;
endpackage

/* logic/fio_sync2.sv */
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module fio_sync2
  import fio_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

/* logic/fio_arbiter.sv */
// Arbiter that lets the core port win and stalls the DMA access
`timescale 1ns/1ps
`default_nettype none
module fio_arbiter
  import fio_pkg::*;
(
  // Requests from the two masters
  input wire logic core_sel_in,
  input wire logic dma_sel_in,
  input wire logic compute_mode_in,
  // Grants and stall
  output logic core_grant_out,
  output logic dma_grant_out,
  output logic dma_stall_out
);
  // Core port always wins; DMA waits on collisions and during compute mode
  assign core_grant_out = core_sel_in;
  assign dma_grant_out = dma_sel_in && !core_sel_in && !compute_mode_in;
  assign dma_stall_out = dma_sel_in && (core_sel_in || compute_mode_in);
endmodule
`default_nettype wire

/* tb/fio_pin_model.sv */
// Pin-side model of the board around one fast I/O port
`timescale 1ns/1ps
`default_nettype none
module fio_pin_model
(
  // Port side
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_oe_n_in,
  // Levels the board puts on pins the port leaves undriven
  input wire logic [31:0] board_level_in,
  // Level seen at each pin
  output logic [31:0] pin_level_out
);
  // Driven pins echo the port, released ones follow the board
  assign pin_level_out = (~pin_oe_n_in & pin_in) | (pin_oe_n_in & board_level_in);
endmodule
`default_nettype wire

/* tb/fio_port_tb.sv */
// Self-checking testbench for the fast I/O port
`timescale 1ns/1ps
`default_nettype none
module fio_port_tb;
  import fio_pkg::*;
  localparam logic [31:0] IMPL = 32'h7fff_ffff;
  localparam logic [31:0] GPIO = 32'h0000_ffff;
  localparam logic [31:0] DIGI = 32'hffff_0fff;
  logic core_clk_in, rst_n_in, c_sel, c_wr, d_sel, d_wr, compute, pc_en, d_ready, d_rvalid;
  logic [31:0] c_addr, c_wdata, c_rdata, d_addr, d_wdata, d_rdata, pin_lvl, pin_o, pin_oe_n, board;
  logic [31:0] ol, dir, inl;
  int miscompares, n_tests, cycles;
  // ====
  // Design and pin model
  fio_port #(.PORT_INDEX(0), .PIN_IMPL_MASK(IMPL)) i_fio_port (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .core_sel_in(c_sel), .core_write_in(c_wr), .core_addr_in(c_addr),
    .core_wdata_in(c_wdata), .core_rdata_out(c_rdata), .dma_sel_in(d_sel), .dma_write_in(d_wr),
    .dma_addr_in(d_addr), .dma_wdata_in(d_wdata), .dma_rdata_out(d_rdata), .dma_ready_out(d_ready),
    .dma_rvalid_out(d_rvalid), .compute_mode_in(compute), .port_ctrl_en_in(pc_en),
    .pin_digital_in(DIGI), .pin_gpio_in(GPIO), .pin_level_in(pin_lvl), .pin_out(pin_o),
    .pin_oe_n_out(pin_oe_n));
  fio_pin_model i_fio_pin_model (.pin_in(pin_o), .pin_oe_n_in(pin_oe_n), .board_level_in(board),
    .pin_level_out(pin_lvl));
  // ====
  // Helpers
  function automatic logic [31:0] a(input logic [5:0] o);
    return FIO_CORE_BASE + {26'h0, o};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Core access; select stays up so accesses can run back to back
  task automatic core(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
    c_sel = 1'b1;
    c_wr = wr;
    c_addr = ad;
    c_wdata = wd;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic rd(input string what, input logic [31:0] ad, input logic [31:0] exp);
    core(1'b0, ad, 32'h0);
    check(what, c_rdata, exp);
  endtask
  task automatic idle(input int n);
    c_sel = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====
  // Clock and hang guard
  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // ====
  // Test sequence
  initial
  begin
    {c_sel, c_wr, d_sel, d_wr, compute, pc_en} = 6'h0;
    {c_addr, c_wdata, d_addr, d_wdata, board} = {5{32'h0}};
    rst_n_in = 1'b0;
    ol = 32'h0;
    dir = 32'h0;
    repeat (4) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    check("pin enables", pin_oe_n, 32'hffff_ffff);
    rd("output level", a(FIO_OFS_OUTPUT_LEVEL), 32'h0);
    rd("direction", a(FIO_OFS_DIRECTION), 32'h0);
    rd("input level", a(FIO_OFS_INPUT_LEVEL), 32'h0);
    idle(1);
    check("read data idle", c_rdata, 32'h0);
    $display("test reset done");
    // Back-to-back strobes with port control off
    core(1'b1, a(FIO_OFS_OUTPUT_LEVEL), 32'hf0f0_a5a5);
    core(1'b1, a(FIO_OFS_SET), 32'h0f00_000f);
    core(1'b1, a(FIO_OFS_CLEAR), 32'h0000_a500);
    core(1'b1, a(FIO_OFS_TOGGLE), 32'hffff_0000);
    ol = ((32'hf0f0_a5a5 | 32'h0f00_000f) & ~32'h0000_a500) ^ 32'hffff_0000;
    rd("output level", a(FIO_OFS_OUTPUT_LEVEL), ol & IMPL);
    rd("set reads", a(FIO_OFS_SET), 32'h0);
    rd("clear reads", a(FIO_OFS_CLEAR), 32'h0);
    rd("toggle reads", a(FIO_OFS_TOGGLE), 32'h0);
    dir = 32'h00ff_00ff;
    core(1'b1, a(FIO_OFS_DIRECTION), dir);
    rd("direction", a(FIO_OFS_DIRECTION), dir & IMPL);
    idle(1);
    check("pin levels", pin_o, ol & dir & GPIO & IMPL);
    check("pin enables", pin_oe_n, ~(dir & GPIO & IMPL));
    $display("test strobes done");
    // Input sampling, freeze and compute mode
    pc_en = 1'b1;
    board = 32'hdead_beef;
    idle(4);
    inl = (((dir & GPIO & IMPL) & ol) | (~(dir & GPIO & IMPL) & board)) & DIGI & IMPL;
    rd("input level", a(FIO_OFS_INPUT_LEVEL), inl);
    pc_en = 1'b0;
    board = ~board;
    idle(4);
    rd("input frozen", a(FIO_OFS_INPUT_LEVEL), inl);
    pc_en = 1'b1;
    compute = 1'b1;
    d_sel = 1'b1;
    d_wr = 1'b0;
    d_addr = a(FIO_OFS_DIRECTION);
    idle(4);
    check("dma ready compute", {31'h0, d_ready}, 32'h0);
    rd("input compute", a(FIO_OFS_INPUT_LEVEL), inl);
    core(1'b1, a(FIO_OFS_SET), 32'h0000_0010);
    ol = ol | 32'h0000_0010;
    rd("output level", a(FIO_OFS_OUTPUT_LEVEL), ol & IMPL);
    c_sel = 1'b0;
    compute = 1'b0;
    @(negedge core_clk_in);
    check("dma ready", {31'h0, d_ready}, 32'h1);
    @(posedge core_clk_in);
    #1;
    d_sel = 1'b0;
    check("dma read valid", {31'h0, d_rvalid}, 32'h1);
    check("dma read data", d_rdata, dir & IMPL);
    $display("test input done");
    // DMA write colliding with a core read
    core(1'b0, a(FIO_OFS_OUTPUT_LEVEL), 32'h0);
    d_sel = 1'b1;
    d_wr = 1'b1;
    d_addr = a(FIO_OFS_TOGGLE);
    d_wdata = 32'h0000_0003;
    c_sel = 1'b1;
    @(negedge core_clk_in);
    check("dma stalled", {31'h0, d_ready}, 32'h0);
    @(posedge core_clk_in);
    #1;
    c_sel = 1'b0;
    check("core read", c_rdata, ol & IMPL);
    @(negedge core_clk_in);
    check("dma ready", {31'h0, d_ready}, 32'h1);
    @(posedge core_clk_in);
    #1;
    d_sel = 1'b0;
    ol = ol ^ 32'h0000_0003;
    rd("output level", a(FIO_OFS_OUTPUT_LEVEL), ol & IMPL);
    $display("test collision done");
    // Next port window and unmapped offset stay out of reach
    core(1'b1, a(FIO_OFS_OUTPUT_LEVEL) + FIO_PORT_STRIDE, 32'hffff_ffff);
    core(1'b1, a(FIO_OFS_SET) + FIO_PORT_STRIDE, 32'hffff_ffff);
    rd("next port", a(FIO_OFS_OUTPUT_LEVEL) + FIO_PORT_STRIDE, 32'h0);
    rd("unmapped", a(6'h18), 32'h0);
    rd("output level", a(FIO_OFS_OUTPUT_LEVEL), ol & IMPL);
    idle(1);
    $display("test map done");
    finish_test();
  end
endmodule
`default_nettype wire
